// ### design/lfc_defines.svh
`ifndef LFC_DEFINES_SVH
`define LFC_DEFINES_SVH

// ----------------------------------------------------------------------------
// flit field positions (128-bit flit, header low 64, tail high 64)
// ----------------------------------------------------------------------------
`define LFC_FLIT_W        128
`define LFC_CMD_LSB       0
`define LFC_CMD_W         6
`define LFC_TAG_LSB       12
`define LFC_TAG_W         11
`define LFC_CUB_LSB       61
`define LFC_CUB_W         3
`define LFC_RRP_LSB       64
`define LFC_FRP_LSB       72
`define LFC_PTR_W         8
`define LFC_SEQ_LSB       80
`define LFC_SEQ_W         3
`define LFC_RTC_LSB       87
`define LFC_RTC_W         7
`define LFC_CRC_LSB       96
`define LFC_CRC_W         32

// ----------------------------------------------------------------------------
// flow command codes and the error response code
// ----------------------------------------------------------------------------
`define LFC_CMD_NULL      6'h00
`define LFC_CMD_POINTER_RETURN_CMD      6'h01
`define LFC_CMD_TOKEN_RETURN_CMD      6'h02
`define LFC_CMD_INIT_RETRY_CMD     6'h03
`define LFC_CMD_ERROR     6'h3E

// ----------------------------------------------------------------------------
// token and init-retry counts
// ----------------------------------------------------------------------------
`define LFC_TOKENS_PER_TOKEN_RETURN_CMD  7'h40
`define LFC_MAX_HOST_TOKENS  10'h3FF
`define LFC_INIT_RETRY_CMD_CNT_W      8
`define LFC_TOKEN_W          10

`endif

// ### design/lfc_pkg.sv
package lfc_pkg;

  typedef struct packed {
    logic [127:0] data;
    logic         last;
  } lfc_flit_t;

  typedef enum logic [2:0] {
    LFC_WAIT_PT   = 3'b000,
    LFC_WAIT_INIT = 3'b001,
    LFC_TOKEN_RETURN_CMD_OUT  = 3'b011,
    LFC_ACTIVE    = 3'b010,
    LFC_RETRY     = 3'b110
  } lfc_state_t;

  typedef struct packed {
    logic [7:0] forward_pointer_field;
    logic [2:0] seq;
    logic       start_retry;
    logic       clear_abort;
  } lfc_tx_ctl_t;

endpackage : lfc_pkg

// ### design/lfc_fifo.sv
`timescale 1ns/1ns
module lfc_fifo #(
  parameter int WIDTH = 129,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_ce,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } lfc_fifo_st_t;

  lfc_fifo_st_t     st_reg;
  lfc_fifo_st_t     st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign o_in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st_reg.cnt != '0);
  assign o_out_data  = mem[st_reg.rd];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = st_reg.wr + AW'(1);
    end
    if (pop) begin
      st_next.rd = st_reg.rd + AW'(1);
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
      if (push) begin
        mem[st_reg.wr] <= i_in_data;
      end
    end
  end
endmodule : lfc_fifo

// ### design/lfc_tail.sv
`timescale 1ns/1ns
`include "lfc_defines.svh"
// fills the tail of a flow flit; crc is supplied from outside the block
module lfc_tail (
  input  wire logic [5:0]                      i_cmd,
  input  wire logic [7:0]                      i_rrp,
  input  wire lfc_pkg::lfc_tx_ctl_t            i_ctl,
  input  wire logic [`LFC_RTC_W-1:0]           i_rtc,
  input  wire logic [31:0]                     i_crc,
  input  wire logic                            i_poison,
  output logic      [`LFC_FLIT_W-1:0]          o_flit
);
  always_comb begin
    o_flit = '0;
    if (i_cmd != `LFC_CMD_NULL) begin
      o_flit[`LFC_CMD_LSB +: `LFC_CMD_W] = i_cmd;
      o_flit[`LFC_RRP_LSB +: `LFC_PTR_W] = i_rrp;
      if (i_cmd == `LFC_CMD_TOKEN_RETURN_CMD) begin
        o_flit[`LFC_FRP_LSB +: `LFC_PTR_W] = i_ctl.forward_pointer_field;
        o_flit[`LFC_SEQ_LSB +: `LFC_SEQ_W] = i_ctl.seq;
        o_flit[`LFC_RTC_LSB +: `LFC_RTC_W] = i_rtc;
      end
      if (i_cmd == `LFC_CMD_INIT_RETRY_CMD) begin
        o_flit[`LFC_FRP_LSB]     = i_ctl.start_retry;
        o_flit[`LFC_FRP_LSB + 1] = i_ctl.clear_abort;
      end
      o_flit[`LFC_CRC_LSB +: `LFC_CRC_W] = i_poison ? ~i_crc : i_crc;
    end
  end
endmodule : lfc_tail

// ### design/lfc_link_flow.sv
`timescale 1ns/1ns
`include "lfc_defines.svh"
// ----------------------------------------------------------------------------
// link flow command unit
// ----------------------------------------------------------------------------
// How it works
// - error link map latched once, at init
// - multi-cube: one error link; single: many
// - received flow flits consumed, never forwarded
// - flow flits sent regardless of tokens
// - codes null 0, pointer_return_cmd 1, token_return_cmd 2, init_retry_cmd 3
// - idle flit all zeros, never poisoned
// - pointer_return_cmd: not stored, seq frp rtc zero
// - token_return_cmd: stored, valid seq and frp
// - retry state sends programmable init_retry_cmd stream
// - init_retry_cmd frp bits: start retry, clear abort
// - poison means inverted crc, detected on receive
// - error response tag low = cube, upper zero
// - request token count ignored in open loop
// - after init send trets, at most 64 tokens each
// - host tokens accepted up to 1023
// - pass-through links init before host trets
// - after training both ends send idle flits
// - posted write tag is ignored
// - four data and one request register sideband
module lfc_link_flow #(
  parameter int INIT_RETRY_CMD_CNT_W = `LFC_INIT_RETRY_CMD_CNT_W,
  parameter int TOKEN_W     = `LFC_TOKEN_W,
  parameter int FIFO_DEPTH  = 4
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_srst,
  input  wire logic                   i_ce,
  // configuration
  input  wire logic                   i_training_done,
  input  wire logic                   i_internal_init_done,
  input  wire logic                   i_passthru_init_done,
  input  wire logic                   i_multi_cube,
  input  wire logic [3:0]             i_err_link_map,
  input  wire logic [2:0]             i_cube_id,
  input  wire logic                   i_open_loop,
  input  wire logic [TOKEN_W-1:0]     i_input_buf_tokens,
  input  wire logic [INIT_RETRY_CMD_CNT_W-1:0] i_init_retry_cmd_len,
  // retry control from retry logic
  input  wire logic                   i_retry_init,
  input  wire logic                   i_start_retry,
  input  wire logic                   i_clear_abort,
  input  wire logic                   i_pointer_return_cmd_req,
  input  wire logic [7:0]             i_rrp,
  input  wire logic [7:0]             i_frp,
  input  wire logic [2:0]             i_seq,
  input  wire logic [31:0]            i_crc,
  // transaction packets toward link
  input  wire logic                   i_pkt_valid,
  output logic                        o_pkt_ready,
  input  wire lfc_pkg::lfc_flit_t     i_pkt,
  input  wire logic                   i_err_rsp_valid,
  // link transmit
  output logic [`LFC_FLIT_W-1:0]      o_tx_flit,
  output logic                        o_tx_store,
  output logic [3:0]                  o_err_link_en,
  // link receive
  input  wire logic                   i_rx_valid,
  input  wire logic [`LFC_FLIT_W-1:0] i_rx_flit,
  input  wire logic [31:0]            i_rx_crc,
  output logic                        o_rx_fwd_valid,
  output logic [`LFC_FLIT_W-1:0]      o_rx_fwd_flit,
  output logic                        o_rx_poisoned,
  output logic                        o_rx_err_flag,
  output logic [TOKEN_W-1:0]          o_host_tokens,
  output logic [7:0]                  o_rx_rrp,
  output logic                        o_link_ready,
  output lfc_pkg::lfc_state_t         o_state
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    lfc_pkg::lfc_state_t    state;
    logic                   map_locked;
    logic [3:0]             err_links;
    logic [TOKEN_W-1:0]     tokens_left;
    logic [TOKEN_W-1:0]     host_tokens;
    logic [INIT_RETRY_CMD_CNT_W-1:0] init_retry_cmd_left;
    logic                   init_retry_cmd_done;
    logic                   link_ready;
    logic                   mid_pkt;
    logic                   host_token_return_cmd_seen;
    logic [`LFC_FLIT_W-1:0] tx_flit;
    logic                   tx_store;
    logic                   fwd_valid;
    logic [`LFC_FLIT_W-1:0] fwd_flit;
    logic                   poisoned;
    logic                   err_flag;
    logic [7:0]             rx_rrp;
  } lfc_st_t;

  lfc_st_t                st_reg;
  lfc_st_t                st_next;
  logic                   q_valid;
  logic                   q_ready;
  lfc_pkg::lfc_flit_t     q_flit;
  logic [5:0]             flow_cmd;
  logic [`LFC_RTC_W-1:0]  flow_rtc;
  logic [`LFC_FLIT_W-1:0] flow_flit;
  lfc_pkg::lfc_tx_ctl_t   tx_ctl;
  logic [5:0]             rx_cmd;
  logic [`LFC_FLIT_W-1:0] err_fix;
  logic [TOKEN_W-1:0]     rx_rtc;
  logic [TOKEN_W:0]       tok_sum;
  logic [TOKEN_W-1:0]     token_return_cmd_chunk;

  // --------------------------------------------------------------------------
  // outbound packet queue
  // --------------------------------------------------------------------------
  lfc_fifo #(
    .WIDTH ($bits(lfc_pkg::lfc_flit_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_ce        (i_ce),
    .i_in_valid  (i_pkt_valid),
    .o_in_ready  (o_pkt_ready),
    .i_in_data   (i_pkt),
    .o_out_valid (q_valid),
    .i_out_ready (q_ready),
    .o_out_data  (q_flit)
  );

  lfc_tail u_tail (
    .i_cmd    (flow_cmd),
    .i_rrp    (i_rrp),
    .i_ctl    (tx_ctl),
    .i_rtc    (flow_rtc),
    .i_crc    (i_crc),
    .i_poison (1'b0),
    .o_flit   (flow_flit)
  );

  assign tx_ctl.forward_pointer_field         = i_frp;
  assign tx_ctl.seq         = i_seq;
  assign tx_ctl.start_retry = i_start_retry;
  assign tx_ctl.clear_abort = i_clear_abort;

  // --------------------------------------------------------------------------
  // transmit selection
  // --------------------------------------------------------------------------
  // transaction flits only flow once tokens are advertised and not during retry
  assign q_ready = (st_reg.state == lfc_pkg::LFC_ACTIVE) && q_valid;

  assign token_return_cmd_chunk = (st_reg.tokens_left > TOKEN_W'(`LFC_TOKENS_PER_TOKEN_RETURN_CMD))
                    ? TOKEN_W'(`LFC_TOKENS_PER_TOKEN_RETURN_CMD) : st_reg.tokens_left;

  always_comb begin
    flow_cmd = `LFC_CMD_NULL;
    flow_rtc = '0;
    // the stream runs one flit past its programmed length; the rest of retry sends idle or pointer returns
    if (st_reg.state == lfc_pkg::LFC_RETRY && !st_reg.init_retry_cmd_done) begin
      flow_cmd = `LFC_CMD_INIT_RETRY_CMD;
    end else if (st_reg.state == lfc_pkg::LFC_TOKEN_RETURN_CMD_OUT) begin
      flow_cmd = `LFC_CMD_TOKEN_RETURN_CMD;
      flow_rtc = token_return_cmd_chunk[`LFC_RTC_W-1:0];
    end else if (i_pointer_return_cmd_req && !st_reg.mid_pkt) begin
      flow_cmd = `LFC_CMD_POINTER_RETURN_CMD;
    end
  end

  // --------------------------------------------------------------------------
  // receive decode
  // --------------------------------------------------------------------------
  assign rx_cmd  = i_rx_flit[`LFC_CMD_LSB +: `LFC_CMD_W];
  assign rx_rtc  = TOKEN_W'(i_rx_flit[`LFC_RTC_LSB +: `LFC_RTC_W]);
  assign tok_sum = {1'b0, st_reg.host_tokens} + {1'b0, rx_rtc};

  // unsolicited error response: tag carries the cube number
  always_comb begin
    err_fix = q_flit.data;
    if (q_flit.data[`LFC_CMD_LSB +: `LFC_CMD_W] == `LFC_CMD_ERROR) begin
      err_fix[`LFC_TAG_LSB +: `LFC_TAG_W] = {8'h00, i_cube_id};
      err_fix[`LFC_CUB_LSB +: `LFC_CUB_W] = i_cube_id;
    end
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.fwd_valid = 1'b0;
    st_next.poisoned  = 1'b0;
    st_next.err_flag  = 1'b0;

    // error link binding is static once initialization finishes
    if (!st_reg.map_locked && i_internal_init_done) begin
      st_next.map_locked = 1'b1;
      if (i_multi_cube) begin
        st_next.err_links = i_err_link_map & (~i_err_link_map + 4'h1);
      end else begin
        st_next.err_links = i_err_link_map;
      end
    end

    unique case (st_reg.state)
      lfc_pkg::LFC_WAIT_PT: begin
        if (i_training_done) begin
          st_next.state = lfc_pkg::LFC_WAIT_INIT;
        end
      end
      lfc_pkg::LFC_WAIT_INIT: begin
        // host-facing trets wait for every pass-through link
        if (i_internal_init_done && i_passthru_init_done) begin
          st_next.state       = lfc_pkg::LFC_TOKEN_RETURN_CMD_OUT;
          st_next.tokens_left = i_input_buf_tokens;
        end
      end
      lfc_pkg::LFC_TOKEN_RETURN_CMD_OUT: begin
        st_next.tokens_left = st_reg.tokens_left - token_return_cmd_chunk;
        if (st_reg.tokens_left <= TOKEN_W'(`LFC_TOKENS_PER_TOKEN_RETURN_CMD)) begin
          st_next.state = lfc_pkg::LFC_ACTIVE;
        end
      end
      lfc_pkg::LFC_ACTIVE: begin
        if (i_retry_init && !st_reg.mid_pkt) begin
          st_next.state      = lfc_pkg::LFC_RETRY;
          st_next.init_retry_cmd_left = i_init_retry_cmd_len;
          st_next.init_retry_cmd_done = 1'b0;
        end
      end
      lfc_pkg::LFC_RETRY: begin
        if (st_reg.init_retry_cmd_left != '0) begin
          st_next.init_retry_cmd_left = st_reg.init_retry_cmd_left - INIT_RETRY_CMD_CNT_W'(1);
        end else begin
          st_next.init_retry_cmd_done = 1'b1;
          if (!i_retry_init) begin
            st_next.state = lfc_pkg::LFC_ACTIVE;
          end
        end
      end
      default: begin
        st_next.state = lfc_pkg::LFC_WAIT_PT;
      end
    endcase

    // transmit: tokens are never checked for flow flits
    if (q_ready) begin
      st_next.tx_flit  = err_fix;
      st_next.tx_store = 1'b1;
      st_next.mid_pkt  = !q_flit.last;
    end else begin
      st_next.tx_flit  = flow_flit;
      st_next.tx_store = (flow_cmd == `LFC_CMD_TOKEN_RETURN_CMD);
      st_next.mid_pkt  = st_reg.mid_pkt;
    end

    // receive: flow flits stop here, others pass up
    if (i_rx_valid) begin
      st_next.poisoned = (i_rx_flit[`LFC_CRC_LSB +: `LFC_CRC_W] == ~i_rx_crc)
                         && (i_rx_flit != '0);
      if (i_rx_flit[`LFC_CMD_LSB +: `LFC_CMD_W] <= `LFC_CMD_INIT_RETRY_CMD) begin
        if (rx_cmd != `LFC_CMD_NULL) begin
          st_next.rx_rrp = i_rx_flit[`LFC_RRP_LSB +: `LFC_PTR_W];
        end
        if (rx_cmd == `LFC_CMD_TOKEN_RETURN_CMD) begin
          st_next.host_token_return_cmd_seen = 1'b1;
          st_next.host_tokens = tok_sum[TOKEN_W] ? `LFC_MAX_HOST_TOKENS
                              : tok_sum[TOKEN_W-1:0];
        end
      end else begin
        st_next.fwd_valid = 1'b1;
        st_next.fwd_flit  = i_rx_flit;
        st_next.rx_rrp    = i_rx_flit[`LFC_RRP_LSB +: `LFC_PTR_W];
        if (i_open_loop) begin
          st_next.fwd_flit[`LFC_RTC_LSB +: `LFC_RTC_W] = '0;
        end else if (st_reg.host_tokens != '0) begin
          st_next.host_tokens = st_reg.host_tokens - TOKEN_W'(1);
        end
        // posted write tag is never looked at; the upper layer gets it as-is
        st_next.err_flag = i_err_rsp_valid;
      end
    end
    st_next.link_ready = st_next.host_token_return_cmd_seen && (st_next.state == lfc_pkg::LFC_ACTIVE);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg       <= '0;
      st_reg.state <= lfc_pkg::LFC_WAIT_PT;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_tx_flit      = st_reg.tx_flit;
  assign o_tx_store     = st_reg.tx_store;
  assign o_err_link_en  = st_reg.err_links;
  assign o_rx_fwd_valid = st_reg.fwd_valid;
  assign o_rx_fwd_flit  = st_reg.fwd_flit;
  assign o_rx_poisoned  = st_reg.poisoned;
  assign o_rx_err_flag  = st_reg.err_flag;
  assign o_host_tokens  = st_reg.host_tokens;
  assign o_rx_rrp       = st_reg.rx_rrp;
  assign o_link_ready   = st_reg.link_ready;
  assign o_state        = st_reg.state;
endmodule : lfc_link_flow

// ### tb/lfc_link_flow_properties.sv
`timescale 1ns/1ns
module lfc_link_flow_properties (
  input wire logic                i_clk,
  input wire logic                i_srst,
  input wire logic                i_ce,
  input wire logic                i_internal_init_done,
  input wire logic                i_passthru_init_done,
  input wire logic                i_rx_valid,
  input wire logic [127:0]        i_rx_flit,
  input wire logic [31:0]         i_rx_crc,
  input wire logic [127:0]        o_tx_flit,
  input wire logic                o_tx_store,
  input wire logic [3:0]          o_err_link_en,
  input wire logic                o_rx_fwd_valid,
  input wire logic [127:0]        o_rx_fwd_flit,
  input wire logic                o_rx_poisoned,
  input wire lfc_pkg::lfc_state_t o_state
);
  wire [5:0] tx_cmd = o_tx_flit[5:0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  AST_IDLE_ZERO: assert property (tx_cmd == 6'h00 |-> o_tx_flit == '0 && !o_tx_store)
    else $error("idle flit not all zero");
  AST_POINTER_RETURN_CMD_ZERO: assert property (tx_cmd == 6'h01 |->
    !o_tx_store && o_tx_flit[82:72] == '0 && o_tx_flit[93:87] == '0)
    else $error("pointer return fields not zero");
  AST_TOKEN_RETURN_CMD_KEPT: assert property (tx_cmd == 6'h02 |-> o_tx_store)
    else $error("token return not stored");
  AST_INIT_RETRY_CMD_ZERO: assert property (tx_cmd == 6'h03 |->
    !o_tx_store && o_tx_flit[82:80] == '0 && o_tx_flit[93:87] == '0)
    else $error("init retry fields wrong");
  AST_NO_FWD_FLOW: assert property (o_rx_fwd_valid |-> o_rx_fwd_flit[5:0] > 6'h03)
    else $error("flow flit forwarded");
  AST_FWD_CAUSE: assert property (o_rx_fwd_valid |-> $past(i_rx_valid))
    else $error("forward without receive");
  AST_POISON: assert property (i_ce && i_rx_valid && i_rx_flit != '0 &&
    i_rx_flit[127:96] == ~i_rx_crc |=> o_rx_poisoned)
    else $error("poison not flagged");
  AST_MAP_STABLE: assert property (o_state == lfc_pkg::LFC_ACTIVE |=> $stable(o_err_link_en))
    else $error("error link map moved");
  AST_PT_FIRST: assert property (o_state == lfc_pkg::LFC_TOKEN_RETURN_CMD_OUT &&
    $past(o_state) == lfc_pkg::LFC_WAIT_INIT |->
    $past(i_passthru_init_done) && $past(i_internal_init_done))
    else $error("token return before pass-through init");
endmodule : lfc_link_flow_properties

// ### tb/lfc_link_partner.sv
`timescale 1ns/1ns
// ----------------------------------------------
// host side receiver: flow flits consumed here
// ----------------------------------------------
module lfc_link_partner (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [127:0] i_flit,
  output int                o_token_return_cmd,
  output int                o_init_retry_cmd,
  output int                o_pointer_return_cmd,
  output logic [7:0]        o_init_retry_cmd_frp
);
  logic [127:0] data_q[$];
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_token_return_cmd <= 0;
      o_init_retry_cmd <= 0;
      o_pointer_return_cmd <= 0;
      o_init_retry_cmd_frp <= 8'h00;
      data_q.delete();
    end else begin
      case (i_flit[5:0])
        6'h00: ;
        6'h01: o_pointer_return_cmd <= o_pointer_return_cmd + 1;
        6'h02: o_token_return_cmd <= o_token_return_cmd + 1;
        6'h03: begin
          o_init_retry_cmd <= o_init_retry_cmd + 1;
          o_init_retry_cmd_frp <= i_flit[79:72];
        end
        default: data_q.push_back(i_flit);
      endcase
    end
  end
endmodule : lfc_link_partner

// ### tb/lfc_link_flow_tb_top.sv
`timescale 1ns/1ns
module lfc_link_flow_tb_top;
  logic i_clk = 0, i_srst = 1, i_ce = 1, i_training_done = 0, i_internal_init_done = 0;
  logic i_passthru_init_done = 0, i_multi_cube = 0, i_open_loop = 0, i_retry_init = 0;
  logic i_start_retry = 0, i_clear_abort = 0, i_pointer_return_cmd_req = 0, i_pkt_valid = 0;
  logic i_err_rsp_valid = 0, i_rx_valid = 0, o_pkt_ready, o_tx_store, o_rx_fwd_valid;
  logic o_rx_poisoned, o_rx_err_flag, o_link_ready;
  logic [3:0]   i_err_link_map = 4'h1, o_err_link_en;
  logic [2:0]   i_cube_id = 3'h0, i_seq = 3'h0;
  logic [9:0]   i_input_buf_tokens = 10'h000, o_host_tokens;
  logic [7:0]   i_init_retry_cmd_len = 8'h00, i_rrp = 8'h00, i_frp = 8'h00, o_rx_rrp;
  logic [31:0]  i_crc = 32'h0000_0000, i_rx_crc = 32'h0000_0000;
  logic [127:0] i_rx_flit = '0, o_tx_flit, o_rx_fwd_flit;
  lfc_pkg::lfc_flit_t  i_pkt = '0;
  lfc_pkg::lfc_state_t o_state;
  logic [127:0] exp_q[$];
  int fails = 0, n_checks = 0;
  int token_return_cmd_n, init_retry_cmd_n, pointer_return_cmd_n;
  logic [7:0] init_retry_cmd_frp;

  lfc_link_flow DUT (.i_clk, .i_srst, .i_ce, .i_training_done, .i_internal_init_done,
    .i_passthru_init_done, .i_multi_cube, .i_err_link_map, .i_cube_id, .i_open_loop,
    .i_input_buf_tokens, .i_init_retry_cmd_len, .i_retry_init, .i_start_retry, .i_clear_abort,
    .i_pointer_return_cmd_req, .i_rrp, .i_frp, .i_seq, .i_crc, .i_pkt_valid, .o_pkt_ready, .i_pkt,
    .i_err_rsp_valid, .o_tx_flit, .o_tx_store, .o_err_link_en, .i_rx_valid, .i_rx_flit,
    .i_rx_crc, .o_rx_fwd_valid, .o_rx_fwd_flit, .o_rx_poisoned, .o_rx_err_flag,
    .o_host_tokens, .o_rx_rrp, .o_link_ready, .o_state);
  lfc_link_partner P (.i_clk, .i_srst, .i_flit(o_tx_flit), .o_token_return_cmd(token_return_cmd_n),
    .o_init_retry_cmd(init_retry_cmd_n), .o_pointer_return_cmd(pointer_return_cmd_n), .o_init_retry_cmd_frp(init_retry_cmd_frp));

  initial forever #20 i_clk = ~i_clk;
  // ----------------------------------------------
  // shared tasks
  // ----------------------------------------------
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic wait_state(input lfc_pkg::lfc_state_t s);
    int k;
    k = 0;
    while (o_state !== s && k < 300) begin
      cyc(1);
      k++;
    end
    chk(o_state, s, "state");
  endtask : wait_state
  task automatic rx(input logic [127:0] f, input logic [31:0] c);
    i_rx_valid = 1;
    i_rx_flit = f;
    i_rx_crc = c;
    i_err_rsp_valid = $urandom;
    cyc(1);
    i_rx_valid = 0;
    i_rx_flit = ~f; // released lines do not keep the last value
  endtask : rx
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------
  // scenarios
  // ----------------------------------------------
  task automatic run_init(input logic [9:0] tok);
    logic [127:0] pk;
    logic [3:0]   m;
    {i_training_done, i_internal_init_done, i_passthru_init_done} = 3'b000;
    i_srst = 1;
    cyc(6);
    i_srst = 0;
    chk(o_tx_flit, '0, "reset flit");
    chk(o_state, lfc_pkg::LFC_WAIT_PT, "reset state");
    i_input_buf_tokens = tok;
    i_multi_cube = $urandom;
    i_err_link_map = 4'($urandom_range(1, 15));
    i_frp = 8'($urandom);
    i_seq = 3'($urandom);
    i_crc = $urandom;
    i_cube_id = 3'($urandom);
    exp_q.delete();
    for (int i = 0; i < 6; i++) begin
      if (o_pkt_ready !== 1'b1) break;
      pk = {$urandom, $urandom, $urandom, $urandom};
      pk[5:0] = (i == 3) ? 6'h3E : 6'h10 + 6'(i);
      i_pkt = {pk, 1'b1};
      i_pkt_valid = 1;
      if (i == 3) begin
        pk[22:12] = {8'h00, i_cube_id};
        pk[63:61] = i_cube_id;
      end
      exp_q.push_back(pk);
      cyc(1);
    end
    i_pkt_valid = 0;
    chk(exp_q.size(), 4, "fifo fill");
    chk(o_pkt_ready, 0, "fifo full");
    i_training_done = 1;
    cyc(2);
    chk(o_state, lfc_pkg::LFC_WAIT_INIT, "trained");
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      chk(o_tx_flit, '0, "idle flit");
    end
    i_internal_init_done = 1;
    cyc(4);
    chk(o_state, lfc_pkg::LFC_WAIT_INIT, "hold for pass-through");
    i_passthru_init_done = 1;
    wait_state(lfc_pkg::LFC_ACTIVE);
    chk(o_link_ready, 0, "link not ready");
    cyc(8);
    chk(token_return_cmd_n, (tok + 63) / 64, "token returns");
    for (int i = 0; i < 4; i++) chk(P.data_q[i], exp_q[i], "drained flit");
    m = i_multi_cube ? (i_err_link_map & (~i_err_link_map + 4'h1)) : i_err_link_map;
    chk(o_err_link_en, m, "error links");
    i_err_link_map = ~i_err_link_map;
    i_multi_cube = ~i_multi_cube;
    cyc(2);
    chk(o_err_link_en, m, "error links held");
    $display("test init %0d done", tok);
  endtask : run_init

  initial begin
    logic [127:0] f;
    logic [31:0]  c;
    logic [4:0]   r;
    int           b;
    void'($urandom(32'haedf_0bd6));
    run_init(10'h040);
    run_init(10'h3ff);
    run_init(10'($urandom_range(1, 1022)));
    r = 5'($urandom_range(23, 31));
    for (int k = 0; k < 4; k++) begin
      f = '0;
      f[5:0] = 6'(k);
      if (k == 2) f[91:87] = r;
      rx(f, 32'h0000_0000);
      chk(o_rx_fwd_valid, 0, "flow not forwarded");
    end
    chk(o_host_tokens, r, "host tokens");
    chk(o_link_ready, 1, "link ready");
    for (int k = 0; k < 2; k++) begin
      i_open_loop = k[0];
      f = {$urandom, $urandom, $urandom, $urandom};
      f[5:0] = 6'h20;
      f[93:87] = 7'($urandom);
      c = f[127:96];
      rx(f, c);
      chk(o_rx_fwd_valid, 1, "forward");
      chk(o_rx_fwd_flit, k ? {f[127:94], 7'h00, f[86:0]} : f, "forward flit");
      chk(o_rx_rrp, f[71:64], "return pointer");
      chk(o_rx_err_flag, i_err_rsp_valid, "error flag");
      chk(o_host_tokens, r - 1, "token use");
    end
    f[127:96] = ~c;
    rx(f, c);
    chk(o_rx_poisoned, 1, "poison");
    $display("test receive done");
    foreach (exp_q[k]) begin
      i_init_retry_cmd_len = (k == 0) ? 8'h00 : 8'($urandom_range(1, 9));
      i_start_retry = 1;
      i_clear_abort = $urandom;
      b = init_retry_cmd_n;
      i_retry_init = 1;
      wait_state(lfc_pkg::LFC_RETRY);
      cyc(i_init_retry_cmd_len + 8);
      i_retry_init = 0;
      wait_state(lfc_pkg::LFC_ACTIVE);
      cyc(2);
      chk(init_retry_cmd_n - b, i_init_retry_cmd_len + 1, "init retry count");
      chk(init_retry_cmd_frp[1:0], {i_clear_abort, 1'b1}, "retry flags");
    end
    $display("test retry done");
    b = pointer_return_cmd_n;
    i_rrp = 8'($urandom);
    i_pointer_return_cmd_req = 1;
    cyc(4);
    i_pointer_return_cmd_req = 0;
    chk(pointer_return_cmd_n > b, 1, "pointer return sent");
    $display("test pointer return done");
    wrap_up();
  end

  initial begin
    #(40 * 20000);
    fails++;
    wrap_up();
  end
endmodule : lfc_link_flow_tb_top

bind lfc_link_flow lfc_link_flow_properties u_props (.i_clk, .i_srst, .i_ce,
  .i_internal_init_done, .i_passthru_init_done, .i_rx_valid, .i_rx_flit, .i_rx_crc,
  .o_tx_flit, .o_tx_store, .o_err_link_en, .o_rx_fwd_valid, .o_rx_fwd_flit,
  .o_rx_poisoned, .o_state);
